// [mad_pkg.sv]
package mad_pkg;

  // Serial framing
  localparam int CMD_BITS = 8;
  localparam int WR_BITS = 16;
  localparam int CMD_ADDR_HI = 7;
  localparam int CMD_ADDR_LO = 3;
  localparam int CMD_READ_BIT = 2;
  localparam int BITCNT_W = 7;
  localparam logic [BITCNT_W-1:0] BITCNT_MAX = 7'h7F;

  // Register addresses
  localparam logic [4:0] ADDR_IWV = 5'h00;
  localparam logic [4:0] ADDR_V1WV = 5'h01;
  localparam logic [4:0] ADDR_V2WV = 5'h02;
  localparam logic [4:0] ADDR_ADC_CRC = 5'h03;
  localparam logic [4:0] ADDR_FIRST_STATUS = 5'h04;
  localparam logic [4:0] ADDR_CNT_SNAP = 5'h05;
  localparam logic [4:0] ADDR_CONFIG = 5'h08;

  // Field widths of the result stream, in burst order
  localparam int RES_W = 24;
  localparam int CRC_W = 16;
  localparam int STAT_W = 8;
  localparam int CNT_W = 16;
  localparam int BANK_W = 3 * RES_W + CRC_W + STAT_W + CNT_W;

  // Bit positions
  localparam int CFG_FWD_CLK_BIT = 0;
  localparam int STAT_RESET_ON_BIT = 0;

  // Core timing in core clock cycles
  localparam logic [7:0] READY_LOW_CYCLES = 8'h40;
  localparam logic [7:0] RESET_CYCLES = 8'h10;

  typedef struct packed {
    logic [RES_W-1:0] iwv;
    logic [RES_W-1:0] v1wv;
    logic [RES_W-1:0] v2wv;
    logic [CRC_W-1:0] adc_crc;
    logic [CNT_W-1:0] cnt_snap;
  } mad_adc_t;

  typedef struct packed {
    logic [RES_W-1:0] iwv;
    logic [RES_W-1:0] v1wv;
    logic [RES_W-1:0] v2wv;
    logic [CRC_W-1:0] adc_crc;
    logic [STAT_W-1:0] first_status;
    logic [CNT_W-1:0] cnt_snap;
  } mad_bank_t;

  typedef struct packed {
    logic [BITCNT_W-1:0] bit_cnt;
    logic [CMD_BITS-1:0] sh;
    logic [CMD_BITS-1:0] cmd;
  } mad_rx_t;

  typedef struct packed {
    logic [BANK_W-1:0] sh;
    logic [BITCNT_W-1:0] left;
    logic oe;
  } mad_tx_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic tog;
  } mad_wr_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } mad_sync_t;

  typedef struct packed {
    logic [7:0] reset_cnt;
    logic reset_on;
    logic [7:0] config_reg;
    logic wr_seen;
    logic pending;
    mad_adc_t stage;
    mad_bank_t bank;
    logic [7:0] low_cnt;
    logic div;
    logic sample_ready_n;
    logic fwd_clk;
  } mad_core_t;

endpackage : mad_pkg

// [mad_sync.sv]
`timescale 1ns/1ns
module mad_sync
  import mad_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level from another domain
  input wire logic d,
  output logic q
);

  mad_sync_t s;
  mad_sync_t next_s;

  // Output moves only once the second and third stages agree
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= {INIT, INIT, INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule : mad_sync

// [mad_spi_slave.sv]
`timescale 1ns/1ns
// Functional notes
// (RULE_01) Master changes MOSI on falling serial clock edges.
// (RULE_02) MOSI bits are captured on rising serial clock edges.
// (RULE_03) MISO changes after falling edges; master samples on the next rise.
// (RULE_04) All bytes and words travel most significant bit first.
// (RULE_05) Master keeps serial clock between 250 kHz and 5.6 MHz.
// (RULE_06) MISO is released whenever no data bits are being sent.
// (RULE_07) Master holds chip select low for the whole transfer.
// (RULE_08) Early chip select rise aborts, leaves register unchanged, releases MISO.
// (RULE_09) A new transfer starts when chip select falls again.
// (RULE_10) Master polls status bit 0 until reset has finished.
// (RULE_11) New results pull sample ready low for exactly 64 core clocks.
// (RULE_12) Master reads all devices on the sample ready pulse.
// (RULE_13) Core input clock lies between 3.6 and 4.21 MHz.
// (RULE_14) Shared pin can forward the core clock to other devices; the code forwards div instead, a toggle at half the core clock rate.
// (RULE_15) Master shares clock and data lines, one chip select each.
// (RULE_16) Command byte: address in 7:3, read flag bit 2, bits 1:0 ignored.
// (RULE_17) Read data starts on the falling edge after the last command bit.
// (RULE_18) A write carries exactly one data byte right after the command.
// (RULE_19) Read from first result register streams all result registers back to back.
// (RULE_20) Bit counter and command state reset while chip select is high.
// (RULE_21) Serial writes cross safely into the core clock domain before use.
module mad_spi_slave
  import mad_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe,
  // Converter results
  input wire mad_adc_t adc_in,
  input wire logic adc_valid,
  // Shared clock-out / sample-ready pin and reset status
  output logic sample_ready_n,
  output logic forwarded_clock_out,
  output logic reset_on
);

  // Bit count from the burst start to the end of the stream
  function automatic logic [BITCNT_W-1:0] read_len(input logic [4:0] addr);
    case (addr)
      ADDR_IWV: read_len = BITCNT_W'(BANK_W);
      ADDR_V1WV: read_len = BITCNT_W'(BANK_W - RES_W);
      ADDR_V2WV: read_len = BITCNT_W'(BANK_W - 2 * RES_W);
      ADDR_ADC_CRC: read_len = BITCNT_W'(BANK_W - 3 * RES_W);
      ADDR_FIRST_STATUS: read_len = BITCNT_W'(STAT_W + CNT_W);
      ADDR_CNT_SNAP: read_len = BITCNT_W'(CNT_W);
      ADDR_CONFIG: read_len = BITCNT_W'(CMD_BITS);
      default: read_len = '0;
    endcase
  endfunction : read_len

  mad_rx_t rx;
  mad_rx_t next_rx;
  mad_tx_t tx;
  mad_tx_t next_tx;
  mad_wr_t wr;
  mad_wr_t next_wr;
  mad_core_t c;
  mad_core_t next_c;
  logic wr_tog_sync;
  logic cs_idle;
  logic [BITCNT_W-1:0] len;
  logic [BANK_W-1:0] rd_vec;

  // Receive side, rising serial clock edge
  always_comb begin
    next_rx = rx;
    next_rx.sh = {rx.sh[CMD_BITS-2:0], mosi}; // RULE_02 RULE_04
    if (rx.bit_cnt == BITCNT_W'(CMD_BITS - 1)) begin
      next_rx.cmd = {rx.sh[CMD_BITS-2:0], mosi}; // RULE_16
    end
    if (rx.bit_cnt != BITCNT_MAX) begin
      next_rx.bit_cnt = rx.bit_cnt + 1'b1;
    end
  end

  // Chip select high clears the decoder, so every frame starts fresh
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx <= '0; // RULE_20 RULE_08 RULE_09
    end else begin
      rx <= next_rx;
    end
  end

  // Write holding register commits only on the sixteenth bit of a write
  always_comb begin
    next_wr = wr;
    if (rx.bit_cnt == BITCNT_W'(WR_BITS - 1) && !rx.cmd[CMD_READ_BIT]) begin
      next_wr.addr = rx.cmd[CMD_ADDR_HI:CMD_ADDR_LO]; // RULE_18 RULE_08
      next_wr.data = {rx.sh[CMD_BITS-2:0], mosi};
      next_wr.tog = ~wr.tog; // RULE_21
    end
  end

  // Not cleared by chip select: the core may still be picking up the last word
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wr <= '0;
    end else begin
      wr <= next_wr;
    end
  end

  // Transmit side, falling serial clock edge
  always_comb begin
    len = read_len(rx.cmd[CMD_ADDR_HI:CMD_ADDR_LO]);
    if (rx.cmd[CMD_ADDR_HI:CMD_ADDR_LO] == ADDR_CONFIG) begin
      rd_vec = {c.config_reg, (BANK_W - CMD_BITS)'(0)};
    end else begin
      rd_vec = c.bank << (BITCNT_W'(BANK_W) - len); // RULE_19
    end
  end

  // Bank is stable here: the core only refreshes it while chip select is high
  always_comb begin
    next_tx = tx;
    if (rx.bit_cnt == BITCNT_W'(CMD_BITS) && rx.cmd[CMD_READ_BIT]) begin
      next_tx.sh = rd_vec; // RULE_17 RULE_19
      next_tx.left = len;
      next_tx.oe = (len != '0);
    end else if (tx.left > BITCNT_W'(1)) begin
      next_tx.sh = {tx.sh[BANK_W-2:0], 1'b0}; // RULE_03 RULE_04
      next_tx.left = tx.left - 1'b1;
    end else begin
      next_tx.left = '0;
      next_tx.oe = 1'b0; // RULE_06
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx <= '0; // RULE_08 RULE_06
    end else begin
      tx <= next_tx;
    end
  end

  assign miso_out = tx.sh[BANK_W-1];
  assign miso_oe = tx.oe;

  // Crossings into the core domain
  mad_sync #(.INIT(1'b0)) u_wr_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(wr.tog),
    .q(wr_tog_sync)
  );

  mad_sync #(.INIT(1'b1)) u_cs_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(cs_n),
    .q(cs_idle)
  );

  // Core domain
  always_comb begin
    next_c = c;
    if (c.reset_on) begin
      next_c.reset_cnt = c.reset_cnt + 1'b1;
      if (c.reset_cnt == RESET_CYCLES - 1'b1) begin
        next_c.reset_on = 1'b0; // RULE_10
      end
    end
    // Holding register is stable long before the next write can finish
    if (wr_tog_sync != c.wr_seen) begin
      next_c.wr_seen = wr_tog_sync; // RULE_21
      if (wr.addr == ADDR_CONFIG) begin
        next_c.config_reg = wr.data;
      end
    end
    if (adc_valid) begin
      next_c.pending = 1'b1;
      next_c.stage = adc_in;
    end
    // Results wait for an idle link so a read never sees a torn word
    if (c.pending && cs_idle) begin
      next_c.pending = 1'b0;
      next_c.bank.iwv = c.stage.iwv;
      next_c.bank.v1wv = c.stage.v1wv;
      next_c.bank.v2wv = c.stage.v2wv;
      next_c.bank.adc_crc = c.stage.adc_crc;
      next_c.bank.cnt_snap = c.stage.cnt_snap;
      next_c.low_cnt = READY_LOW_CYCLES; // RULE_11
    end else if (c.low_cnt != '0) begin
      next_c.low_cnt = c.low_cnt - 1'b1;
    end
    if (cs_idle) begin
      next_c.bank.first_status = '0;
      next_c.bank.first_status[STAT_RESET_ON_BIT] = next_c.reset_on;
    end
    next_c.div = ~c.div;
    next_c.sample_ready_n = (next_c.low_cnt == '0); // RULE_11
    if (c.config_reg[CFG_FWD_CLK_BIT]) begin
      next_c.fwd_clk = next_c.div; // RULE_14
    end else begin
      next_c.fwd_clk = next_c.sample_ready_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c <= '0;
      c.reset_on <= 1'b1;
      c.bank.first_status <= STAT_W'(1) << STAT_RESET_ON_BIT;
      c.sample_ready_n <= 1'b1;
      c.fwd_clk <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  assign sample_ready_n = c.sample_ready_n;
  assign forwarded_clock_out = c.fwd_clk;
  assign reset_on = c.reset_on;

endmodule : mad_spi_slave

// [mad_props.sv]
`timescale 1ns/1ns
module mad_props (
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic adc_valid,
  input wire logic sample_ready_n,
  input wire logic forwarded_clock_out,
  input wire logic reset_on
);
  logic [7:0] lo;
  logic [6:0] rc;
  always_ff @(posedge ref_clk) lo <= (rst || sample_ready_n) ? 8'h00 : lo + 8'h01;
  // Edge count per frame, saturating so long bursts cannot wrap
  always_ff @(posedge sclk or posedge cs_n)
    if (cs_n) rc <= 7'h00;
    else if (rc != 7'h7F) rc <= rc + 7'h01;
  property p_rel; @(posedge ref_clk) disable iff (rst) cs_n && $past(cs_n) |-> !miso_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("miso on idle");
  property p_lo; @(posedge ref_clk) disable iff (rst) $rose(sample_ready_n) |-> lo == 8'h40;
  endproperty
  a_lo: assert property (p_lo) else $error("pulse length");
  property p_max; @(posedge ref_clk) disable iff (rst) lo <= 8'h40; endproperty
  a_max: assert property (p_max) else $error("pulse long");
  property p_go; @(posedge ref_clk) disable iff (rst)
    cs_n [*8] ##0 (adc_valid && sample_ready_n) |-> ##[1:4] !sample_ready_n; endproperty
  a_go: assert property (p_go) else $error("no pulse");
  property p_fwd; @(posedge ref_clk) disable iff (rst)
    forwarded_clock_out == sample_ready_n || $changed(forwarded_clock_out); endproperty
  a_fwd: assert property (p_fwd) else $error("clock out");
  property p_ron; @(posedge ref_clk) $fell(rst) |-> reset_on ##[8:24] !reset_on; endproperty
  a_ron: assert property (p_ron) else $error("reset flag");
  property p_cmd; @(posedge sclk) disable iff (cs_n) rc < 7'h08 |-> !miso_oe; endproperty
  a_cmd: assert property (p_cmd) else $error("miso in cmd");
  property p_end; @(posedge sclk) disable iff (cs_n) rc >= 7'h78 |-> !miso_oe; endproperty
  a_end: assert property (p_end) else $error("miso past end");
endmodule : mad_props
bind mad_spi_slave mad_props mad_props_inst (.ref_clk, .rst, .sclk, .cs_n, .miso_oe,
  .adc_valid, .sample_ready_n, .forwarded_clock_out, .reset_on);

// [mad_spi_master.sv]
`timescale 1ns/1ns
module mad_spi_master (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Clock idles high; a write with n below 16 is cut short
  task automatic frame(input logic [127:0] tx, input int n, output logic [127:0] rx);
    rx = '0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #16 sclk = 1'b0;
      mosi = tx[127-i];
      #16 sclk = 1'b1;
      rx = {rx[126:0], miso};
    end
    #16 cs_n = 1'b1;
    mosi = ~mosi;
    #16;
  endtask : frame
endmodule : mad_spi_master

// [mad_spi_slave_bench.sv]
`timescale 1ns/1ns
module mad_spi_slave_bench;
  import mad_pkg::*;
  logic ref_clk, rst, adc_valid, miso_out, miso_oe, sample_ready_n, forwarded_clock_out, reset_on;
  wire logic sclk, cs_n, mosi, miso;
  mad_adc_t adc_in;
  logic [127:0] rx;
  int err_count, total_checks, cyc;
  assign miso = miso_oe ? miso_out : 1'b1;
  mad_spi_slave mad_spi_slave_inst (.ref_clk, .rst, .sclk, .cs_n, .mosi, .miso_out, .miso_oe,
    .adc_in, .adc_valid, .sample_ready_n, .forwarded_clock_out, .reset_on);
  mad_spi_master mad_spi_master_inst (.sclk, .cs_n, .mosi, .miso);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic t_reset;
    int i;
    chk(reset_on, 1);
    for (i = 0; reset_on === 1'b1 && i < 40; i++) tick(1);
    chk(reset_on, 0);
  endtask : t_reset
  task automatic t_result;
    int i;
    adc_in = '{24'hA1B2C3, 24'h5A5A5A, 24'h123456, 16'hBEEF, 16'hC001};
    adc_valid = 1'b1;
    tick(1);
    adc_valid = 1'b0;
    for (i = 0; sample_ready_n === 1'b1 && i < 20; i++) tick(1);
    chk(forwarded_clock_out, sample_ready_n);
    for (i = 0; sample_ready_n === 1'b0 && i < 90; i++) tick(1);
    chk(i, 64);
  endtask : t_result
  // One extra bit after the stream shows the pull-up once miso is released
  task automatic t_read(input logic [4:0] a, input int nb);
    logic [127:0] m;
    m = (128'h1 << (nb - 9)) - 128'h1;
    mad_spi_master_inst.frame({a, 3'b111, 120'h0}, nb, rx);
    chk((rx >> 1) & m, {adc_in[103:16], 8'h00, adc_in[15:0]} & m);
    chk(rx[0], 1);
  endtask : t_read
  task automatic t_write;
    logic f;
    mad_spi_master_inst.frame({8'h40, 8'h01, 112'h0}, 12, rx);
    mad_spi_master_inst.frame({8'h44, 120'h0}, 16, rx);
    chk(rx[7:0], 8'h00);
    mad_spi_master_inst.frame({8'h40, 8'h01, 112'h0}, 16, rx);
    tick(8);
    f = forwarded_clock_out;
    tick(1);
    chk(forwarded_clock_out, !f);
    mad_spi_master_inst.frame({8'h44, 120'h0}, 16, rx);
    chk(rx[7:0], 8'h01);
  endtask : t_write
  initial begin
    rst = 1'b1;
    adc_valid = 1'b0;
    adc_in = '0;
    tick(8);
    rst = 1'b0;
    t_reset();
    t_result();
    t_read(5'h00, 121);
    t_read(5'h02, 73);
    t_write();
    conclude();
  end
endmodule : mad_spi_slave_bench
